/* File: pancfg_top.v */
// negotiation, crossover, strap capture and isolate control of a 10/100 transceiver
// Functional notes
// - send advertised abilities while negotiation enabled
// - resolve 100FD, 100HD, 10FD, 10HD priority
// - forced speed/duplex bits when negotiation off
// - constant capability bits, T4 reads zero
// - status shows complete, fault, link, preamble
// - advertise all by default, writes restrict
// - capture partner words, load parallel codes
// - expansion flags fault, pages, partner able
// - parallel detect configures single valid link
// - parallel detect sets bit 5/7, selector
// - parallel detect: partner able zero, complete
// - fault when both 100 and 10 links good
// - restart bit restarts negotiation
// - lost link resumes negotiation
// - break link timer silences line first
// - auto crossover default, strap, register
// - force crossover bit, no auto when forced
// - latch station address from straps
// - strapped zero isolates, written zero not
// - isolate bit enters isolate mode
// - isolate gates MII, management and line stay
// - straps set advertisement bits 8:5
`timescale 1ns/1ps
`include "pancfg_defines.vh"
module pancfg_top #(
	parameter [31:0] BREAK_CYCLES = `PANCFG_BREAK_CYCLES
) (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// management register port
	input wire [4:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	// strap pins
	input wire [4:0] station_address_strap,
	input wire negotiation_enable_strap,
	input wire mode_select_strap_low,
	input wire mode_select_strap_high,
	input wire auto_crossover_strap,
	// line side receivers and code word exchange
	input wire link_ok_100,
	input wire link_ok_10,
	input wire page_rx_valid,
	input wire [15:0] page_rx_word,
	input wire partner_np_able,
	input wire remote_fault,
	// line side control
	output reg flp_enable,
	output reg line_quiet,
	output reg speed_100,
	output reg full_duplex,
	output reg crossover,
	output reg link_up,
	// MII gating
	output wire mii_tx_accept,
	output wire mii_out_enable
);
	localparam ST_IDLE = 3'd0;
	localparam ST_BREAK = 3'd1;
	localparam ST_NEG = 3'd2;
	localparam ST_UP = 3'd3;
	localparam ST_FORCED = 3'd4;
	reg rst_a;
	reg rst_n;
	reg [15:0] bmc;
	reg [15:0] adv;
	reg [15:0] lpa;
	reg [1:0] pcc_x;
	reg [4:0] station_addr;
	reg strap_iso;
	reg pd_fault;
	reg page_seen;
	reg lp_an_able;
	reg an_done;
	reg [2:0] state;
	reg [31:0] timer;
	reg [7:0] seed;
	reg strap_taken;
	reg [2:0] strap_wait;
	reg forced_boot;
	reg en_cleared;
	wire [8:0] straps_s;
	wire l100;
	wire l10;
	wire s_an;
	wire s_a1;
	wire s_a0;
	wire s_ax;
	wire [4:0] s_addr;
	wire [15:0] bms;
	wire [15:0] common;
	wire isolated;
	wire an_active;
	// priority resolution of the common ability set
	function [1:0] pancfg_resolve;
		input [15:0] c;
		begin
			if (c[8])
				pancfg_resolve = 2'b11;
			else if (c[7])
				pancfg_resolve = 2'b10;
			else if (c[6])
				pancfg_resolve = 2'b01;
			else
				pancfg_resolve = 2'b00;
		end
	endfunction
	// reset release through two flops
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end
	// strap and link level inputs pass the three stage synchroniser
	pancfg_sync3 #(.W(9)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.din({auto_crossover_strap, mode_select_strap_high, mode_select_strap_low,
			negotiation_enable_strap, station_address_strap[4:0]}),
		.dout(straps_s)
	);
	assign s_addr = straps_s[4:0];
	assign s_an = straps_s[5];
	assign s_a0 = straps_s[6];
	assign s_a1 = straps_s[7];
	assign s_ax = straps_s[8];
	pancfg_sync3 #(.W(2)) u_sync_link (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.din({link_ok_100, link_ok_10}),
		.dout({l100, l10})
	);
	assign bms = `PANCFG_BMS_CONST | {10'h000, an_done, remote_fault, 1'b0, link_up, 2'b00};
	assign common = adv & lpa;
	assign an_active = bmc[`PANCFG_BMC_ANEN];
	// strapped zero or bit 10 isolates
	assign isolated = bmc[`PANCFG_BMC_ISOLATE] | strap_iso;
	// MII gated, management and line untouched
	assign mii_tx_accept = ~isolated;
	assign mii_out_enable = ~isolated;
	// register read mux
	always @*
	begin
		if (reg_addr == `PANCFG_ADDR_BMC)
			reg_rdata = bmc;
		else if (reg_addr == `PANCFG_ADDR_BMS)
			reg_rdata = bms;
		else if (reg_addr == `PANCFG_ADDR_ADV)
			reg_rdata = adv;
		else if (reg_addr == `PANCFG_ADDR_LPA)
			reg_rdata = lpa;
		else if (reg_addr == `PANCFG_ADDR_EXP)
			reg_rdata = {11'h000, pd_fault, partner_np_able, 1'b0, page_seen, lp_an_able};
		else if (reg_addr == `PANCFG_ADDR_STS)
			reg_rdata = {11'h000, 1'b0, 1'b0, ~full_duplex ^ 1'b1, ~speed_100, link_up};
		else if (reg_addr == `PANCFG_ADDR_PCC)
			reg_rdata = {pcc_x, 9'h000, station_addr};
		else
			reg_rdata = 16'h0000;
	end
	// registers, negotiation state machine and line control
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bmc <= 16'h0000;
			adv <= `PANCFG_ADV_SELECTOR;
			lpa <= 16'h0000;
			pcc_x <= 2'b10;
			station_addr <= 5'h00;
			strap_iso <= 1'b0;
			strap_taken <= 1'b0;
			strap_wait <= 3'd0;
			forced_boot <= 1'b0;
			en_cleared <= 1'b0;
			pd_fault <= 1'b0;
			page_seen <= 1'b0;
			lp_an_able <= 1'b0;
			an_done <= 1'b0;
			state <= ST_IDLE;
			timer <= 32'h0;
			seed <= `PANCFG_SEED_RESET;
			flp_enable <= 1'b0;
			line_quiet <= 1'b1;
			speed_100 <= 1'b0;
			full_duplex <= 1'b0;
			crossover <= 1'b0;
			link_up <= 1'b0;
		end
		else
		begin
			seed <= {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
			// let the strap synchroniser settle before latching
			if (!strap_taken && strap_wait != 3'd5)
				strap_wait <= strap_wait + 3'd1;
			else if (!strap_taken)
			begin
				strap_taken <= 1'b1;
				station_addr <= s_addr;
				strap_iso <= (s_addr == 5'h00);
				pcc_x <= {s_ax, 1'b0};
				forced_boot <= ~s_an;
				bmc[`PANCFG_BMC_ANEN] <= s_an;
				bmc[`PANCFG_BMC_SPEED] <= s_a1;
				bmc[`PANCFG_BMC_DUPLEX] <= s_a0;
				if (!s_an)
					adv[8:5] <= 4'hf;
				else if ({s_a1, s_a0} == 2'b00)
					adv[8:5] <= 4'h3;
				else if ({s_a1, s_a0} == 2'b01)
					adv[8:5] <= 4'hc;
				else if ({s_a1, s_a0} == 2'b10)
					adv[8:5] <= 4'h5;
				else
					adv[8:5] <= 4'hf;
				state <= s_an ? ST_NEG : ST_FORCED;
			end
			else
			begin
				// management writes
				if (reg_wr && reg_addr == `PANCFG_ADDR_BMC)
				begin
					bmc <= reg_wdata & 16'h3700;
					// forced start needs enable cleared then set
					if (!reg_wdata[`PANCFG_BMC_ANEN])
						en_cleared <= 1'b1;
				end
				if (reg_wr && reg_addr == `PANCFG_ADDR_ADV)
					adv <= {reg_wdata[15:5], 5'h01};
				if (reg_wr && reg_addr == `PANCFG_ADDR_PCC)
				begin
					pcc_x <= reg_wdata[15:14];
					station_addr <= reg_wdata[4:0];
				end
				// capture base and next page words
				if (page_rx_valid)
				begin
					lpa <= page_rx_word;
					page_seen <= 1'b1;
					lp_an_able <= 1'b1;
				end
				else if (reg_rd && reg_addr == `PANCFG_ADDR_EXP)
					page_seen <= 1'b0;
				if (reg_rd && reg_addr == `PANCFG_ADDR_EXP && !(state == ST_NEG && l100 && l10))
					pd_fault <= 1'b0;
				case (state)
					ST_FORCED:
					begin
						speed_100 <= bmc[`PANCFG_BMC_SPEED];
						full_duplex <= bmc[`PANCFG_BMC_DUPLEX];
						flp_enable <= 1'b0;
						line_quiet <= 1'b0;
						link_up <= bmc[`PANCFG_BMC_SPEED] ? l100 : l10;
						// only forced crossover in forced mode
						crossover <= pcc_x[0];
						an_done <= 1'b0;
						if (an_active && (!forced_boot || en_cleared))
						begin
							timer <= BREAK_CYCLES;
							state <= ST_BREAK;
						end
					end
					ST_BREAK:
					begin
						// silence line until break timer expires
						flp_enable <= 1'b0;
						line_quiet <= 1'b1;
						link_up <= 1'b0;
						an_done <= 1'b0;
						if (timer <= 32'd1)
							state <= ST_NEG;
						else
							timer <= timer - 32'd1;
					end
					ST_NEG:
					begin
						flp_enable <= 1'b1;
						line_quiet <= 1'b0;
						if (!pcc_x[1])
							crossover <= pcc_x[0];
						else if (timer[19:0] == 20'h00000)
							crossover <= seed[0];
						timer <= timer + 32'd1;
						// fault when both 100 and 10 links good
						if (l100 && l10)
							pd_fault <= 1'b1;
						if (page_rx_valid)
						begin
							speed_100 <= pancfg_resolve(adv & page_rx_word) >= 2'b10;
							full_duplex <= pancfg_resolve(adv & page_rx_word) == 2'b11
								|| pancfg_resolve(adv & page_rx_word) == 2'b01;
							an_done <= 1'b1;
							link_up <= 1'b0; // link confirmed once receivers report it
							state <= ST_UP;
						end
						// single valid link configures that technology
						else if (l100 ^ l10)
						begin
							lpa <= l100 ? `PANCFG_LPA_PD100 : `PANCFG_LPA_PD10;
							lp_an_able <= 1'b0;
							speed_100 <= l100;
							full_duplex <= 1'b0;
							an_done <= 1'b1;
							link_up <= 1'b1;
							state <= ST_UP;
						end
					end
					ST_UP:
					begin
						link_up <= l100 | l10;
						if (link_up && !(l100 | l10))
						begin
							timer <= BREAK_CYCLES;
							state <= ST_BREAK;
						end
					end
					default:
						state <= ST_FORCED;
				endcase
				if (reg_wr && reg_addr == `PANCFG_ADDR_BMC && reg_wdata[`PANCFG_BMC_RESTART]
					&& reg_wdata[`PANCFG_BMC_ANEN] && state != ST_FORCED)
				begin
					timer <= BREAK_CYCLES;
					state <= ST_BREAK;
				end
				else if (reg_wr && reg_addr == `PANCFG_ADDR_BMC && !reg_wdata[`PANCFG_BMC_ANEN])
					state <= ST_FORCED;
			end
		end
	end
endmodule // pancfg_top

/* File: pancfg_defines.vh */
// register offsets, field positions, reset values and timing counts of the negotiation block
`ifndef PANCFG_DEFINES_VH
`define PANCFG_DEFINES_VH
`define PANCFG_ADDR_BMC 5'h00
`define PANCFG_ADDR_BMS 5'h01
`define PANCFG_ADDR_ADV 5'h04
`define PANCFG_ADDR_LPA 5'h05
`define PANCFG_ADDR_EXP 5'h06
`define PANCFG_ADDR_STS 5'h10
`define PANCFG_ADDR_PCC 5'h19
`define PANCFG_BMC_RESTART 9
`define PANCFG_BMC_ISOLATE 10
`define PANCFG_BMC_ANEN 12
`define PANCFG_BMC_SPEED 13
`define PANCFG_BMC_DUPLEX 8
`define PANCFG_PCC_AUTOX 15
`define PANCFG_PCC_FORCEX 14
`define PANCFG_BMS_CONST 16'h7849
`define PANCFG_ADV_SELECTOR 16'h0001
`define PANCFG_LPA_PD100 16'h0081
`define PANCFG_LPA_PD10 16'h0021
`define PANCFG_PCC_RESET_HI 11'h600
`define PANCFG_BREAK_MS 1500
`define PANCFG_CLK_KHZ 125000
`define PANCFG_BREAK_CYCLES (`PANCFG_BREAK_MS * `PANCFG_CLK_KHZ)
`define PANCFG_SEED_RESET 8'h5a
`endif

/* File: pancfg_sync3.v */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`include "pancfg_defines.vh"
module pancfg_sync3 #(
	parameter W = 1
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// data
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	// shift chain, output changes when stage 2 and 3 agree
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= {W{1'b0}};
			s2 <= {W{1'b0}};
			s3 <= {W{1'b0}};
			dout <= {W{1'b0}};
		end
		else
		begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				dout <= s3;
		end
	end
endmodule // pancfg_sync3

/* File: pancfg_partner.sv */
// remote link partner: receiver link levels and received code words
`timescale 1ns/1ps
module pancfg_partner (
	// clock
	input wire core_clk,
	// line side levels and words
	output reg link_ok_100,
	output reg link_ok_10,
	output reg page_rx_valid,
	output reg [15:0] page_rx_word,
	output reg partner_np_able,
	output reg remote_fault
);
	integer i;
	// idle partner with no link and no next pages
	initial
	begin
		link_ok_100 = 1'b0;
		link_ok_10 = 1'b0;
		page_rx_valid = 1'b0;
		page_rx_word = 16'h0000;
		partner_np_able = 1'b0;
		remote_fault = 1'b0;
	end
	// link levels change just after a falling edge
	task set_link(input l100, input l10);
	begin
		@(negedge core_clk);
		link_ok_100 = l100;
		link_ok_10 = l10;
	end
	endtask
	// base page sent three times, word inverted while not valid
	task send_page(input [15:0] w);
	begin
		for (i = 0; i < 3; i = i + 1)
		begin
			@(negedge core_clk);
			page_rx_valid = 1'b1;
			page_rx_word = w;
			@(negedge core_clk);
			page_rx_valid = 1'b0;
			page_rx_word = ~w;
		end
	end
	endtask
endmodule // pancfg_partner

/* File: pancfg_top_asserts.sv */
// port checker of the negotiation and isolate control block
`timescale 1ns/1ps
module pancfg_top_chk (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// register port
	input wire [4:0] reg_addr,
	input wire reg_wr,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	// line and mii side
	input wire flp_enable,
	input wire line_quiet,
	input wire speed_100,
	input wire full_duplex,
	input wire crossover,
	input wire mii_tx_accept,
	input wire mii_out_enable
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	AST_BMS: assert property (reg_addr == 5'h01 |-> // capability bits
		reg_rdata[15:11] == 5'h0f && reg_rdata[6] && reg_rdata[3] && reg_rdata[0])
		else $error("status capability bits wrong");
	AST_ADV: assert property (reg_addr == 5'h04 |-> reg_rdata[4:0] == 5'h01) // selector
		else $error("advertisement selector wrong");
	AST_MII: assert property (mii_tx_accept == mii_out_enable) // both gated
		else $error("mii gates differ");
	AST_RESTART: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[12] &&
		reg_wdata[9] |=> ##1 (line_quiet && !flp_enable) [*8])
		else $error("restart did not silence line");
	AST_QUIET: assert property (line_quiet |-> !flp_enable) // no bursts
		else $error("bursts while quiet");
	AST_FORCED: assert property ((reg_addr == 5'h00 && !reg_rdata[12] && !line_quiet &&
		$stable(reg_rdata)) [*3] |-> speed_100 == reg_rdata[13] && full_duplex == reg_rdata[8])
		else $error("forced mode not applied");
	AST_ISO: assert property ((reg_addr == 5'h00 && reg_rdata[10] && // isolate bit
		$stable(reg_rdata)) [*2] |-> !mii_out_enable)
		else $error("isolate bit not applied");
	AST_FORCEX: assert property ((reg_addr == 5'h19 && reg_rdata[14] && // forced cross
		$stable(reg_rdata)) [*3] |-> crossover)
		else $error("forced crossover missing");
	AST_PCCZ: assert property (reg_wr && reg_addr == 5'h19 && mii_out_enable // no isolate
		|=> mii_out_enable)
		else $error("address write isolated");
endmodule // pancfg_top_chk
bind pancfg_top pancfg_top_chk chk_u (.core_clk(core_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.flp_enable(flp_enable), .line_quiet(line_quiet), .speed_100(speed_100),
	.full_duplex(full_duplex), .crossover(crossover), .mii_tx_accept(mii_tx_accept),
	.mii_out_enable(mii_out_enable));

/* File: pancfg_top_tb.sv */
// self-checking bench of the negotiation and isolate control block
`timescale 1ns/1ps
module pancfg_top_tb;
	localparam BRK = 20;
	reg core_clk, resetn, reg_wr, reg_rd;
	reg [4:0] reg_addr, strap;
	reg [15:0] reg_wdata, got;
	reg [15:0] ws [$];
	reg [1:0] e;
	wire [15:0] reg_rdata, pw;
	wire l100, l10, pv, np, rf, flp, quiet, spd, fdx, xov, lnk, txa, moe;
	integer n_mismatch, comparisons, seed, k, n;
	pancfg_top #(.BREAK_CYCLES(BRK)) dut_u (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .station_address_strap(strap),
		.negotiation_enable_strap(1'b1), .mode_select_strap_low(1'b1),
		.mode_select_strap_high(1'b1), .auto_crossover_strap(1'b1), .link_ok_100(l100),
		.link_ok_10(l10), .page_rx_valid(pv), .page_rx_word(pw), .partner_np_able(np),
		.remote_fault(rf), .flp_enable(flp), .line_quiet(quiet), .speed_100(spd),
		.full_duplex(fdx), .crossover(xov), .link_up(lnk), .mii_tx_accept(txa),
		.mii_out_enable(moe));
	pancfg_partner partner_u (.core_clk(core_clk), .link_ok_100(l100), .link_ok_10(l10),
		.page_rx_valid(pv), .page_rx_word(pw), .partner_np_able(np), .remote_fault(rf));
	// resolution model: 100 full, 100 half, 10 full, 10 half
	function [1:0] res(input [15:0] c);
		res = c[8] ? 2'b11 : c[7] ? 2'b10 : c[6] ? 2'b01 : 2'b00;
	endfunction
	task chk(input [8*10-1:0] nm, input [15:0] ex, input [15:0] g);
	begin
		comparisons = comparisons + 1;
		if (g !== ex)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %0s expected %h seen %h", nm, ex, g);
		end
	end
	endtask
	task wr(input [4:0] a, input [15:0] d);
	begin
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	end
	endtask
	task rd(input [4:0] a);
	begin
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		got = reg_rdata;
		@(negedge core_clk);
		reg_rd = 1'b0;
	end
	endtask
	// bounded wait for bursts (0) or link (1)
	task wt(input integer s);
	begin
		n = 0;
		while ((s ? lnk : flp) !== 1'b1 && n < 400)
		begin
			@(negedge core_clk);
			n = n + 1;
		end
		chk("wait", 16'h1, {15'h0, n < 400});
	end
	endtask
	task end_sim;
	begin
		$display("counts: %0d compares, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		#200000;
		n_mismatch = n_mismatch + 1;
		end_sim;
	end
	// main sequence
	initial
	begin
		seed = 67037;
		n_mismatch = 0;
		comparisons = 0;
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h1f;
		reg_wdata = 16'h0000;
		k = $random(seed);
		strap = 5'h01 + k[4:0] % 5'h1f;
		ws = {16'h01e1, 16'h00e1, 16'h0061, 16'h0021};
		repeat (5) @(negedge core_clk);
		resetn = 1'b1;
		repeat (8) @(negedge core_clk);
		rd(5'h19);
		chk("pcc", {1'b1, 10'h0, strap}, got & 16'h801f);
		rd(5'h04);
		chk("adv", 16'h01e1, got & 16'h01ff);
		rd(5'h01);
		chk("bms", 16'h7849, got & 16'hffcb);
		rd(5'h1e);
		chk("unmapped", 16'h0, got);
		$display("test straps done");
		wr(5'h19, 16'h8000);
		chk("pcc zero", 16'h1, moe);
		wr(5'h00, 16'h1400);
		chk("iso", 16'h0, moe);
		chk("iso tx", 16'h0, txa);
		rd(5'h04);
		chk("iso adv", 16'h01e1, got & 16'h01ff);
		wr(5'h00, 16'h1000);
		chk("iso off", 16'h1, moe);
		$display("test isolate done");
		foreach (ws[i])
		begin
			wr(5'h00, 16'h1200);
			@(negedge core_clk);
			chk("quiet", 16'h1, quiet);
			wt(0);
			chk("break", 16'h1, n >= BRK - 2);
			partner_u.send_page(ws[i]);
			e = res(ws[i] & 16'h01e0);
			partner_u.set_link(e[1], !e[1]);
			wt(1);
			chk("speed", e[1], spd);
			chk("duplex", e[0], fdx);
			rd(5'h05);
			chk("lpa", ws[i], got);
			partner_u.set_link(1'b0, 1'b0);
			repeat (8) @(negedge core_clk);
			chk("relink", 16'h1, flp | quiet);
		end
		$display("test negotiate done");
		for (k = 0; k < 2; k = k + 1)
		begin
			wr(5'h00, 16'h1200);
			wt(0);
			partner_u.set_link(k == 0, k == 1);
			wt(1);
			rd(5'h05);
			chk("pd lpa", k ? 16'h0021 : 16'h0081, got);
			chk("pd speed", k == 0, spd);
			rd(5'h06);
			chk("pd able", 16'h0, got[0]);
			rd(5'h01);
			chk("pd done", 16'h1, got[5]);
			partner_u.set_link(1'b0, 1'b0);
		end
		wr(5'h00, 16'h1200);
		wt(0);
		partner_u.set_link(1'b1, 1'b1);
		repeat (20) @(negedge core_clk);
		rd(5'h06);
		chk("pd fault", 16'h1, got[4]);
		partner_u.set_link(1'b0, 1'b0);
		$display("test parallel done");
		wr(5'h00, 16'h2100);
		repeat (BRK + 4) @(negedge core_clk);
		chk("frc spd", 16'h1, spd);
		chk("frc fdx", 16'h1, fdx);
		wr(5'h00, 16'h0000);
		repeat (BRK + 4) @(negedge core_clk);
		chk("frc spd0", 16'h0, spd);
		chk("frc fdx0", 16'h0, fdx);
		wr(5'h19, 16'h4000);
		repeat (4) @(negedge core_clk);
		chk("xover", 16'h1, xov);
		wr(5'h19, 16'h0000);
		repeat (4) @(negedge core_clk);
		chk("xover off", 16'h0, xov);
		wr(5'h00, 16'h1000);
		$display("test forced done");
		end_sim;
	end
endmodule // pancfg_top_tb
